/* File: shared/uart_pkg.sv */
// constants, register map and states of the serial unit
// assumes one clock and a 32-bit bus with byte addresses
package uart_pkg;
    localparam int ADDR_W = 5;
    // register byte offsets
    localparam logic [4:0] CTRL_ONE_OFS = 5'h00;
    localparam logic [4:0] STATUS_OFS   = 5'h04;
    localparam logic [4:0] DATA_OFS     = 5'h08;
    localparam logic [4:0] BAUD_OFS     = 5'h0C;
    // control_one fields
    localparam int CTRL_W          = 10;
    localparam int WORD_LEN_BIT    = 0;
    localparam int WAKE_SEL_BIT    = 1;
    localparam int PAR_EN_BIT      = 2;
    localparam int PAR_POL_BIT     = 3;
    localparam int PAR_IE_BIT      = 4;
    localparam int MUTE_BIT        = 5;
    localparam int TX_EN_BIT       = 6;
    localparam int RX_EN_BIT       = 7;
    localparam int LIN_SLAVE_BIT   = 8;
    localparam int RX_IE_BIT       = 9;
    // status fields
    localparam int RDF_BIT         = 0;
    localparam int PE_BIT          = 1;
    localparam int QUIET_BIT       = 2;
    localparam int TXE_BIT         = 3;
    // baud register fields
    localparam int PRESC_HI = 7;
    localparam int PRESC_LO = 6;
    localparam int TXDIV_HI = 5;
    localparam int TXDIV_LO = 3;
    localparam int RXDIV_HI = 2;
    localparam int RXDIV_LO = 0;
    localparam logic [7:0]        BAUD_RESET = 8'h00;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 10'h000;
    // prescaler factors and divider width (13 * 128 fits 11 bits)
    localparam int DIV_W = 11;
    localparam logic [DIV_W-1:0] PRESC_F0 = 11'h001;
    localparam logic [DIV_W-1:0] PRESC_F1 = 11'h003;
    localparam logic [DIV_W-1:0] PRESC_F2 = 11'h004;
    localparam logic [DIV_W-1:0] PRESC_F3 = 11'h00D;
    // oversampling
    localparam logic [3:0] OVS_LAST = 4'hF;
    localparam logic [3:0] SMP_A    = 4'h7;
    localparam logic [3:0] SMP_C    = 4'h9;
    localparam logic [8:0] MASK_7   = 9'h07F;
    localparam logic [8:0] MASK_8   = 9'h0FF;
    localparam logic [3:0] BITS_8   = 4'h8;
    localparam logic [3:0] BITS_9   = 4'h9;
    localparam logic [7:0] IDLE_10  = 8'h9F; // ten bit times of 16 ticks, minus one
    localparam logic [7:0] IDLE_11  = 8'hAF;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        LN_IDLE  = 4'b0001,
        LN_START = 4'b0010,
        LN_DATA  = 4'b0100,
        LN_STOP  = 4'b1000
    } line_state_type;
endpackage : uart_pkg

/* File: shared/baud_if.sv */
// baud config down, 16x rate enables back
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface baud_if;
    logic [7:0] cfg;
    logic       tx_run;
    logic       rx_run;
    logic       tx_tick;
    logic       rx_tick;
    modport gen  (input cfg, input tx_run, input rx_run, output tx_tick, output rx_tick);
    modport user (output cfg, output tx_run, output rx_run, input tx_tick, input rx_tick);
endinterface : baud_if

/* File: rtl/baud_gen.sv */
// baud generator: one-cycle enables at 16x the tx and rx rates
// assumes the divider fields stay still while a direction runs
`timescale 1ns/1ps
module baud_gen
    import uart_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    baud_if.gen      bi
);
    typedef struct packed {
        logic [DIV_W-1:0] tx_cnt;
        logic [DIV_W-1:0] rx_cnt;
        logic             tx_tick;
        logic             rx_tick;
    } gen_state_type;

    gen_state_type s_reg, s_next;

    // prescaler times power-of-two divisor
    function automatic logic [DIV_W-1:0] div_factor(input logic [1:0] p, input logic [2:0] d);
        logic [DIV_W-1:0] f;
        case (p)
            2'h0:    f = PRESC_F0;
            2'h1:    f = PRESC_F1;
            2'h2:    f = PRESC_F2;
            default: f = PRESC_F3;
        endcase
        return DIV_W'(f << d);
    endfunction : div_factor

    assign bi.tx_tick = s_reg.tx_tick;
    assign bi.rx_tick = s_reg.rx_tick;

    // two counters share the prescaler code
    always_comb begin
        logic [DIV_W-1:0] tx_lim;
        logic [DIV_W-1:0] rx_lim;
        tx_lim = div_factor(bi.cfg[PRESC_HI:PRESC_LO], bi.cfg[TXDIV_HI:TXDIV_LO]) - 1'b1;
        rx_lim = div_factor(bi.cfg[PRESC_HI:PRESC_LO], bi.cfg[RXDIV_HI:RXDIV_LO]) - 1'b1;
        s_next = s_reg;
        s_next.tx_tick = 1'b0;
        s_next.rx_tick = 1'b0;
        if (!bi.tx_run || s_reg.tx_cnt >= tx_lim) begin
            s_next.tx_cnt  = '0;
            s_next.tx_tick = bi.tx_run;
        end else begin
            s_next.tx_cnt = s_reg.tx_cnt + 1'b1;
        end
        if (!bi.rx_run || s_reg.rx_cnt >= rx_lim) begin
            s_next.rx_cnt  = '0;
            s_next.rx_tick = bi.rx_run;
        end else begin
            s_next.rx_cnt = s_reg.rx_cnt + 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
endmodule : baud_gen

/* File: rtl/uart_mute_parity_baud.sv */
// serial unit: receiver muting, parity, baud divider
// assumes an AXI4-Lite master and a line synchronous to aclk
//
// Notes on behaviour
// - mute request sleeps the receiver: no rx flags, no rx interrupts.
// - muted receiver wakes on idle line (wake select 0) or address mark (1).
// - idle-line wake clears the mute request, line quiet flag stays clear.
// - address mark wake clears mute, sets data full, keeps the word.
// - parity made and checked only with parity enable set.
// - frames: 8 data; 7 data+parity; 9 data; 8 data+parity, all start/stop.
// - parity gives even ones with polarity 0, odd with 1, over 7/8 bits.
// - with parity on, parity replaces the top data bit written.
// - failed parity sets parity error, interrupts if parity interrupt on.
// - address mark uses the top data bit, never the parity bit.
// - baud divider only applies while LIN slave mode is off.
// - bits 7:6 pick prescaler 1, 3, 4 or 13.
// - bits 5:3 pick transmit divisor two to the code.
// - bits 2:0 pick receive divisor two to the code, independent of tx.
// - baud divider resets to zero.
// - bit rate is clock over 16, prescaler and divisor.
// - 16 samples per bit, vote on 8th to 10th, resync on start.
`timescale 1ns/1ps
module uart_mute_parity_baud
    import uart_pkg::*;
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    input  wire logic              serial_in,
    output logic                   serial_out,
    output logic                   irq
);
    typedef struct packed {
        logic [CTRL_W-1:0] ctrl;
        logic [7:0]        baud;
        logic [8:0]        rx_data;
        logic [8:0]        tx_data;
        logic              rdf;
        logic              pe;
        logic              quiet;
        logic              txe;
        line_state_type    rx_st;
        logic [3:0]        rx_cnt;
        logic [3:0]        rx_bit;
        logic [1:0]        rx_votes;
        logic [8:0]        rx_shift;
        logic [7:0]        idle_cnt;
        logic              idle_armed;
        line_state_type    tx_st;
        logic [3:0]        tx_cnt;
        logic [3:0]        tx_bit;
        logic [8:0]        tx_shift;
        logic              out;
        logic              aw_got;
        logic              w_got;
        logic [ADDR_W-1:0] aw_a;
        logic [31:0]       w_d;
        logic [3:0]        w_s;
        logic              awr;
        logic              wr;
        logic              bv;
        logic [1:0]        br;
        logic              arr;
        logic              rv;
        logic [31:0]       rd;
        logic [1:0]        rr;
        logic              irq;
    } core_state_type;

    core_state_type s_reg, s_next;
    baud_if         bi ();

    baud_gen u_baud (
        .aclk    (aclk),
        .aresetn (aresetn),
        .bi      (bi)
    );

    // parity bit over the low 7 or 8 bits, even for polarity 0
    function automatic logic parity_bit(input logic [8:0] w, input logic m, input logic pol);
        return (^(w & (m ? MASK_8 : MASK_7))) ^ pol;
    endfunction : parity_bit

    // byte-lane merge of a bus write
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // LIN slave mode stops the divider
    assign bi.cfg    = s_reg.baud;
    assign bi.tx_run = s_reg.ctrl[TX_EN_BIT] && !s_reg.ctrl[LIN_SLAVE_BIT];
    assign bi.rx_run = s_reg.ctrl[RX_EN_BIT] && !s_reg.ctrl[LIN_SLAVE_BIT];

    assign awready    = s_reg.awr;
    assign wready     = s_reg.wr;
    assign bvalid     = s_reg.bv;
    assign bresp      = s_reg.br;
    assign arready    = s_reg.arr;
    assign rvalid     = s_reg.rv;
    assign rdata      = s_reg.rd;
    assign rresp      = s_reg.rr;
    assign serial_out = s_reg.out;
    assign irq        = s_reg.irq;

    always_comb begin
        logic       m;
        logic       parity_control_enable;
        logic       mute;
        logic [3:0] nbits;
        logic [8:0] word;
        logic       msb;
        logic       perr;
        logic       set_rdf;
        logic       set_pe;
        logic       set_quiet;
        logic       unmute;
        logic [8:0] txw;
        logic [31:0] wimg;
        m         = s_reg.ctrl[WORD_LEN_BIT];
        parity_control_enable       = s_reg.ctrl[PAR_EN_BIT];
        mute      = s_reg.ctrl[MUTE_BIT];
        nbits     = m ? BITS_9 : BITS_8;
        word      = m ? s_reg.rx_shift : 9'(s_reg.rx_shift >> 1);
        // address mark uses the top data bit, not parity
        msb       = parity_control_enable ? (m ? word[7] : word[6]) : (m ? word[8] : word[7]);
        perr      = parity_control_enable && (parity_bit(word, m, s_reg.ctrl[PAR_POL_BIT]) != (m ? word[8] : word[7]));
        set_rdf   = 1'b0;
        set_pe    = 1'b0;
        set_quiet = 1'b0;
        unmute    = 1'b0;
        txw       = '0;
        wimg      = '0;
        s_next    = s_reg;

        // receiver: start hunt, voting on samples 8 to 10 of each bit
        if (!s_reg.ctrl[RX_EN_BIT]) begin
            s_next.rx_st      = LN_IDLE;
            s_next.idle_armed = 1'b0;
        end else if (bi.rx_tick) begin
            s_next.rx_cnt = s_reg.rx_cnt + 1'b1;
            if (s_reg.rx_cnt >= SMP_A && s_reg.rx_cnt <= SMP_C && serial_in) begin
                s_next.rx_votes = s_reg.rx_votes + 1'b1;
            end
            case (s_reg.rx_st)
                LN_IDLE: begin
                    s_next.rx_cnt = '0;
                    if (!serial_in) begin
                        // sampling phase restarts on each start edge
                        s_next.rx_st    = LN_START;
                        s_next.rx_cnt   = 4'h1;
                        s_next.rx_votes = '0;
                        s_next.idle_cnt = '0;
                    end else if (s_reg.idle_armed) begin
                        // idle tracked even when muted so it can wake us
                        s_next.idle_cnt = s_reg.idle_cnt + 1'b1;
                        if (s_reg.idle_cnt == (m ? IDLE_11 : IDLE_10)) begin
                            s_next.idle_armed = 1'b0;
                            if (mute) begin
                                unmute = !s_reg.ctrl[WAKE_SEL_BIT];
                            end else begin
                                set_quiet = 1'b1;
                            end
                        end
                    end
                end
                LN_START: begin
                    if (s_reg.rx_cnt == OVS_LAST) begin
                        s_next.rx_votes = '0;
                        s_next.rx_bit   = '0;
                        s_next.rx_st    = s_reg.rx_votes[1] ? LN_IDLE : LN_DATA; // glitch rejected
                    end
                end
                LN_DATA: begin
                    if (s_reg.rx_cnt == OVS_LAST) begin
                        s_next.rx_shift = {s_reg.rx_votes[1], s_reg.rx_shift[8:1]};
                        s_next.rx_votes = '0;
                        s_next.rx_bit   = s_reg.rx_bit + 1'b1;
                        if (s_reg.rx_bit == nbits - 1'b1) begin
                            s_next.rx_st = LN_STOP;
                        end
                    end
                end
                LN_STOP: begin
                    if (s_reg.rx_cnt == OVS_LAST) begin
                        s_next.rx_st      = LN_IDLE;
                        s_next.rx_votes   = '0;
                        s_next.idle_armed = 1'b1;
                        s_next.idle_cnt   = '0;
                        if (!mute || (s_reg.ctrl[WAKE_SEL_BIT] && msb)) begin
                            unmute          = mute;
                            set_rdf         = 1'b1;
                            set_pe          = perr;
                            s_next.rx_data  = word;
                        end
                    end
                end
                default: s_next.rx_st = LN_IDLE;
            endcase
        end

        // transmitter: single holding register feeding the shifter
        if (!s_reg.ctrl[TX_EN_BIT]) begin
            s_next.tx_st = LN_IDLE;
            s_next.out   = 1'b1;
        end else begin
            case (s_reg.tx_st)
                LN_IDLE: begin
                    s_next.out = 1'b1;
                    if (!s_reg.txe && bi.tx_tick) begin
                        txw = s_reg.tx_data;
                        if (parity_control_enable) begin
                            // parity replaces the top written bit
                            txw[nbits - 1'b1] = parity_bit(s_reg.tx_data, m, s_reg.ctrl[PAR_POL_BIT]);
                        end
                        s_next.tx_shift = txw;
                        s_next.txe      = 1'b1;
                        s_next.tx_st    = LN_START;
                        s_next.tx_cnt   = '0;
                        s_next.tx_bit   = '0;
                        s_next.out      = 1'b0;
                    end
                end
                LN_START, LN_DATA, LN_STOP: begin
                    if (bi.tx_tick) begin
                        s_next.tx_cnt = s_reg.tx_cnt + 1'b1; // 16 ticks per bit
                        if (s_reg.tx_cnt == OVS_LAST) begin
                            if (s_reg.tx_st == LN_STOP) begin
                                s_next.tx_st = LN_IDLE;
                            end else if (s_reg.tx_st == LN_START) begin
                                s_next.tx_st = LN_DATA;
                                s_next.out   = s_reg.tx_shift[0];
                            end else if (s_reg.tx_bit == nbits - 1'b1) begin
                                s_next.tx_st = LN_STOP;
                                s_next.out   = 1'b1;
                            end else begin
                                s_next.tx_shift = 9'(s_reg.tx_shift >> 1);
                                s_next.tx_bit   = s_reg.tx_bit + 1'b1;
                                s_next.out      = s_reg.tx_shift[1];
                            end
                        end
                    end
                end
                default: s_next.tx_st = LN_IDLE;
            endcase
        end

        // hw clears mute; a software write below wins
        if (unmute) begin
            s_next.ctrl[MUTE_BIT] = 1'b0;
        end

        // bus write: aw and w in either order
        if (awvalid && s_reg.awr) begin
            s_next.aw_got = 1'b1;
            s_next.aw_a   = awaddr;
        end
        if (wvalid && s_reg.wr) begin
            s_next.w_got = 1'b1;
            s_next.w_d   = wdata;
            s_next.w_s   = wstrb;
        end
        if (s_reg.bv && bready) begin
            s_next.bv = 1'b0;
        end
        if (s_reg.aw_got && s_reg.w_got && !s_reg.bv) begin
            s_next.aw_got = 1'b0;
            s_next.w_got  = 1'b0;
            s_next.bv     = 1'b1;
            s_next.br     = RESP_OKAY;
            wimg          = merge('0, s_reg.w_d, s_reg.w_s);
            case (s_reg.aw_a)
                CTRL_ONE_OFS: s_next.ctrl = CTRL_W'(merge(32'(s_next.ctrl), s_reg.w_d, s_reg.w_s));
                STATUS_OFS: begin
                    // write one to clear; a hardware set wins below
                    s_next.rdf   = s_reg.rdf & !wimg[RDF_BIT];
                    s_next.pe    = s_reg.pe & !wimg[PE_BIT];
                    s_next.quiet = s_reg.quiet & !wimg[QUIET_BIT];
                end
                DATA_OFS: begin
                    // dropped while the holding register is full
                    if (s_reg.txe) begin
                        s_next.tx_data = 9'(merge(32'(s_reg.tx_data), s_reg.w_d, s_reg.w_s));
                        s_next.txe     = 1'b0;
                    end
                end
                BAUD_OFS: s_next.baud = 8'(merge(32'(s_reg.baud), s_reg.w_d, s_reg.w_s));
                default:  s_next.br = RESP_SLVERR;
            endcase
        end
        s_next.awr = !s_next.aw_got && !s_next.bv;
        s_next.wr  = !s_next.w_got && !s_next.bv;

        // sets after clears so no event is lost
        s_next.rdf   = s_next.rdf | set_rdf;
        s_next.pe    = s_next.pe | set_pe;
        s_next.quiet = s_next.quiet | set_quiet;

        // bus read: one in flight, answer a cycle after the take
        if (s_reg.rv && rready) begin
            s_next.rv  = 1'b0;
            s_next.arr = 1'b1;
        end
        if (arvalid && s_reg.arr) begin
            s_next.arr = 1'b0;
            s_next.rv  = 1'b1;
            s_next.rr  = RESP_OKAY;
            s_next.rd  = '0;
            case (araddr)
                CTRL_ONE_OFS: s_next.rd = 32'(s_reg.ctrl);
                STATUS_OFS: begin
                    s_next.rd[RDF_BIT]   = s_reg.rdf;
                    s_next.rd[PE_BIT]    = s_reg.pe;
                    s_next.rd[QUIET_BIT] = s_reg.quiet;
                    s_next.rd[TXE_BIT]   = s_reg.txe;
                end
                DATA_OFS: s_next.rd = 32'(s_reg.rx_data);
                BAUD_OFS: s_next.rd = 32'(s_reg.baud);
                default:  s_next.rr = RESP_SLVERR;
            endcase
        end

        // receive requests held off while muted
        s_next.irq = !s_next.ctrl[MUTE_BIT] &&
                     ((s_next.ctrl[RX_IE_BIT] && (s_next.rdf || s_next.quiet)) ||
                      (s_next.ctrl[PAR_IE_BIT] && s_next.pe));
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg       <= '0;
            s_reg.ctrl  <= CTRL_RESET;
            s_reg.baud  <= BAUD_RESET;
            s_reg.txe   <= 1'b1;
            s_reg.out   <= 1'b1;
            s_reg.rx_st <= LN_IDLE;
            s_reg.tx_st <= LN_IDLE;
            s_reg.awr   <= 1'b1;
            s_reg.wr    <= 1'b1;
            s_reg.arr   <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end
endmodule : uart_mute_parity_baud

/* File: testbench/uart_mute_parity_baud_checker.sv */
// bus handshake and line timing assertions
// assumes binding to the top; sees only its ports
`timescale 1ns/1ps
module uart_mute_parity_baud_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic serial_out
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // one answer per request; bvalid registers one edge after both are held
    wr_answer_a: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
        else $error("write response late");
    wr_block_a: assert property (bvalid |-> !awready && !wready)
        else $error("write taken in response");
    wr_one_a: assert property (bvalid && bready |=> !bvalid)
        else $error("write response repeated");
    rd_answer_a: assert property (arvalid && arready |=> rvalid)
        else $error("read data late");
    rd_block_a: assert property (rvalid |-> !arready)
        else $error("read taken in response");
    rd_one_a: assert property (rvalid && rready |=> !rvalid)
        else $error("read data repeated");
    // a line level lasts a bit; checked for at least 8 cycles
    tx_low_a: assert property ($fell(serial_out) |-> !serial_out [*8])
        else $error("short low level");
    tx_high_a: assert property ($rose(serial_out) |-> serial_out [*8])
        else $error("short high level");
endmodule : uart_mute_parity_baud_checker

bind uart_mute_parity_baud uart_mute_parity_baud_checker u_chk (.aclk, .aresetn, .awvalid, .awready,
    .wvalid, .wready, .bvalid, .bready, .arvalid, .arready, .rvalid, .rready, .serial_out);

/* File: testbench/serial_node.sv */
// another node on the line: sends and captures frames
// assumes lsb first, idle high, bit period in aclk cycles
`timescale 1ns/1ps
module serial_node (
    input wire logic aclk,
    input wire logic rx_line,
    output logic     tx_line
);
    initial tx_line = 1'b1;
    // start, n bits, stop; back to back keeps gaps short
    task automatic send(input logic [9:0] w, input int n, input int p);
        tx_line <= 1'b0;
        repeat (p) @(posedge aclk);
        for (int i = 0; i < n; i++) begin
            tx_line <= w[i];
            repeat (p) @(posedge aclk);
        end
        tx_line <= 1'b1;
        repeat (p) @(posedge aclk);
    endtask : send
    // samples mid bit, so small tick skew is harmless
    task automatic get(output logic [9:0] w, input int n, input int p);
        w = '0;
        @(negedge rx_line);
        repeat (p / 2) @(posedge aclk);
        for (int i = 0; i < n; i++) begin
            repeat (p) @(posedge aclk);
            w[i] = rx_line;
        end
    endtask : get
endmodule : serial_node

/* File: testbench/tb_uart_mute_parity_baud.sv */
// bench: bus master and partner node, checked against a model
// assumes baud 0 gives 16 cycles a bit
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_uart_mute_parity_baud import uart_pkg::*; ();
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, serial_in;
    logic        awready, wready, bvalid, arready, rvalid, serial_out, irq;
    logic [4:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rd_data;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, last_resp;
    logic [9:0]  got;
    logic [8:0]  d;
    int          mismatches, n_checks;
    uart_mute_parity_baud DUT (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .serial_in, .serial_out, .irq);
    serial_node node (.aclk, .rx_line(serial_out), .tx_line(serial_in));
    always #20 aclk = ~aclk;
    // each channel drops at its own take
    task automatic wr(input logic [4:0] a, input logic [31:0] v);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= v;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        last_resp = bresp;
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [4:0] a);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rd_data   = rdata;
        last_resp = rresp;
        rready <= 1'b0;
    endtask : rd
    // sent word: parity replaces the top bit
    function automatic logic [8:0] expw(logic [8:0] v, logic m, logic parity_control_enable, logic ps);
        if (parity_control_enable) v[m ? 8 : 7] = ^(v & (m ? MASK_8 : MASK_7)) ^ ps;
        return v & {m, 8'hFF};
    endfunction : expw
    function automatic logic [31:0] cw(logic [2:0] f, logic [31:0] more);
        return 32'(f[0]) << WORD_LEN_BIT | 32'(f[1]) << PAR_EN_BIT | 32'(f[2]) << PAR_POL_BIT | more;
    endfunction : cw
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : finish_test
    initial begin
        repeat (30000) @(posedge aclk);
        mismatches++;
        finish_test();
    end
    initial begin
        {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, mismatches, n_checks} = '0;
        wstrb = 4'hF;
        void'($urandom(32'h194d_8f81));
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(BAUD_OFS);
        `CHK("baud reset", 32'h0000_0000, rd_data)
        rd(5'h10);
        `CHK("unmapped resp", RESP_SLVERR, last_resp)
        wr(5'h10, 32'h0000_0000);
        `CHK("unmapped wr", RESP_SLVERR, last_resp)
        // every tx format and polarity
        for (int i = 0; i < 8; i++) begin
            d = 9'($urandom);
            wr(CTRL_ONE_OFS, cw(i[2:0], 1 << TX_EN_BIT));
            fork
                node.get(got, i[0] ? 9 : 8, 16);
                wr(DATA_OFS, 32'(d));
            join
            `CHK("tx word", 10'(expw(d, i[0], i[1], i[2])), got)
            repeat (40) @(posedge aclk);
        end
        // rx parity on/off, good and bad
        for (int i = 0; i < 4; i++) begin
            wr(CTRL_ONE_OFS, cw({1'b0, i[1], 1'b0}, (1 << RX_EN_BIT) | (1 << PAR_IE_BIT)));
            d = expw(9'($urandom), 1'b0, 1'b1, 1'b0) ^ (9'(i[0]) << 7);
            node.send(10'(d), 8, 16);
            repeat (4) @(posedge aclk);
            rd(STATUS_OFS);
            `CHK("parity flag", i[0] & i[1], rd_data[PE_BIT])
            `CHK("parity irq", i[0] & i[1], irq)
            wr(STATUS_OFS, 32'h0000_0007);
        end
        // idle wake: silent while muted, quiet stays clear
        wr(CTRL_ONE_OFS, (1 << RX_EN_BIT) | (1 << MUTE_BIT) | (1 << RX_IE_BIT));
        node.send(10'h0A5, 8, 16);
        node.send(10'h05A, 8, 16);
        rd(STATUS_OFS);
        `CHK("muted flags", 3'h0, rd_data[2:0])
        `CHK("muted irq", 1'b0, irq)
        repeat (200) @(posedge aclk);
        rd(CTRL_ONE_OFS);
        `CHK("idle wake", 1'b0, rd_data[MUTE_BIT])
        rd(STATUS_OFS);
        `CHK("no quiet", 3'h0, rd_data[2:0])
        // address mark: parity bit never wakes, top data bit does
        wr(CTRL_ONE_OFS, cw(3'b011, (1 << RX_EN_BIT) | (1 << MUTE_BIT) | (1 << WAKE_SEL_BIT)));
        node.send(10'h100, 9, 16);
        node.send(10'h180, 9, 16);
        repeat (4) @(posedge aclk);
        rd(STATUS_OFS);
        `CHK("mark flag", 3'h1, rd_data[2:0])
        rd(DATA_OFS);
        `CHK("mark word", 9'h180, rd_data[8:0])
        rd(CTRL_ONE_OFS);
        `CHK("mark unmute", 1'b0, rd_data[MUTE_BIT])
        // prescaler 3, tx div 2, rx div 1, set while disabled
        wr(CTRL_ONE_OFS, 32'h0000_0000);
        wr(BAUD_OFS, 32'h0000_0048);
        rd(BAUD_OFS);
        `CHK("baud readback", 32'h0000_0048, rd_data)
        wr(CTRL_ONE_OFS, (1 << TX_EN_BIT) | (1 << RX_EN_BIT));
        d = 9'($urandom) & 9'h0FF;
        fork
            node.get(got, 8, 96);
            wr(DATA_OFS, 32'(d));
            node.send(10'(~d) & 10'h0FF, 8, 48);
        join
        `CHK("tx at rate", 10'(d), got)
        rd(DATA_OFS);
        `CHK("rx at rate", ~d & 9'h0FF, rd_data[8:0])
        // lin slave mode stops the divider
        repeat (200) @(posedge aclk);
        wr(CTRL_ONE_OFS, (1 << TX_EN_BIT) | (1 << LIN_SLAVE_BIT));
        wr(DATA_OFS, 32'h0000_0000);
        repeat (30) @(posedge aclk);
        `CHK("lin holds line", 1'b1, serial_out)
        finish_test();
    end
endmodule : tb_uart_mute_parity_baud
